// *** design/iso_block_pkg.sv ***
// Summary of operation
// - Classify each block as I, R or S.
// - R-blocks carry no INF, answer last block.
// - Only DESELECT supported; never send WTX.
// - No CID or NAD, received or sent.
// - Chained segments must be 64 bytes minimum.
// - Answer every S(DESELECT) with S(DESELECT).
// - Tag block number starts at 1.
// - Received I-block toggles tag block number.
// - Differing R(ACK) toggles; R(NAK) keeps number.
// - Reader speaks first; tag only answers.
// - Chained I-block is acknowledged with R(ACK).
// - Unchained I-block gets an I-block reply.
// - Matching R(ACK/NAK) resends last I-block unchanged.
// - Differing R(NAK) is answered with R(ACK).
// - Differing R(ACK) while chaining sends next segment.
// - Data field never exceeds 254 bytes.
// - Each block closes with two-byte CRC_B.
package iso_block_pkg;
  localparam logic [7:0] PCB_I_BASE  = 8'h02;
  localparam logic [7:0] PCB_R_ACK   = 8'hA2;
  localparam logic [7:0] PCB_S_DESEL = 8'hC2;
  localparam logic [7:0] PCB_S_WTX   = 8'hF2;
  localparam logic [7:0] MASK_I      = 8'hE2;
  localparam logic [7:0] MASK_R      = 8'hEE;
  localparam int         BIT_BN      = 0;
  localparam int         BIT_NAD     = 2;
  localparam int         BIT_CID     = 3;
  localparam int         BIT_CHAIN   = 4;
  localparam int         BIT_NAK     = 4;
  localparam int         FRAME_MAX   = 256;
  localparam int         CRC_LEN     = 2;
  localparam int         DATA_MAX    = FRAME_MAX - CRC_LEN;
  localparam int         BUF_DEPTH   = DATA_MAX - 1;
  localparam int         CHAIN_MIN   = 64;
  localparam logic       BN_INIT     = 1'b1;
  typedef enum logic [1:0] {BLK_I, BLK_R, BLK_S, BLK_BAD} blk_e;
  typedef enum logic [2:0] {ACT_NONE, ACT_APP, ACT_RACK, ACT_RETX, ACT_SDES} act_e;
endpackage : iso_block_pkg

// *** design/iso14443_4_block_protocol.sv ***
`timescale 1ns/1ps
`default_nettype none
module iso14443_4_block_protocol (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       activate,
  input  wire logic       rxValid,
  input  wire logic [7:0] rxByte,
  input  wire logic       rxLast,
  input  wire logic       rxCrcOk,
  output logic            appValid,
  output logic [7:0]      appByte,
  output logic            appEnd,
  output logic            appGood,
  output logic            appChained,
  input  wire logic       replyValid,
  input  wire logic [7:0] replyByte,
  input  wire logic       replyLast,
  input  wire logic       replyMore,
  output logic            replyReady,
  output logic            txValid,
  output logic [7:0]      txByte,
  output logic            txLast,
  input  wire logic       txReady,
  output logic            deselected,
  output logic            blockNum,
  output logic            chaining
);
  typedef enum logic [1:0] {ST_IDLE, ST_APP, ST_SEND, ST_HALT} state_e;

  state_e     state_q;
  logic [7:0] rxPcb_q;
  logic [8:0] rxCnt_q;
  logic       rxBad_q;
  logic       bn_q;
  logic       chainTx_q;
  logic       lastIValid_q;
  logic [7:0] lastIPcb_q;
  logic [7:0] txPcb_q;
  logic       shortTx_q;
  logic       deselPend_q;
  logic [7:0] buf_q [0:iso_block_pkg::BUF_DEPTH-1];
  logic [7:0] len_q;
  logic [7:0] wr_q;
  logic [8:0] txIdx_q;
  logic       appValid_q;
  logic [7:0] appByte_q;
  logic       appEnd_q;
  logic       appGood_q;
  logic       appChained_q;

  function automatic iso_block_pkg::blk_e classify(input logic [7:0] pcb);
    if ((pcb & iso_block_pkg::MASK_I) == iso_block_pkg::PCB_I_BASE && !pcb[iso_block_pkg::BIT_CID]
        && !pcb[iso_block_pkg::BIT_NAD])
      classify = iso_block_pkg::BLK_I;
    else if ((pcb & iso_block_pkg::MASK_R) == iso_block_pkg::PCB_R_ACK)
      classify = iso_block_pkg::BLK_R;
    else if (pcb == iso_block_pkg::PCB_S_DESEL)
      classify = iso_block_pkg::BLK_S;
    else
      classify = iso_block_pkg::BLK_BAD;
  endfunction : classify

  logic                rxTake;
  logic                fe;
  logic [7:0]          pcbNow;
  iso_block_pkg::blk_e blk;
  iso_block_pkg::act_e act;
  logic                bnNext;
  logic                replyTake;
  logic                replyEnd;
  logic                txTake;

  assign rxTake    = ce && rxValid && state_q == ST_IDLE && !activate;
  assign fe        = rxTake && rxLast;
  assign pcbNow    = (rxCnt_q == 9'h000) ? rxByte : rxPcb_q;
  assign blk       = classify(pcbNow);
  assign replyReady = state_q == ST_APP;
  assign replyTake = ce && replyValid && state_q == ST_APP && !activate;
  assign replyEnd  = replyTake && (replyLast || wr_q == 8'(iso_block_pkg::BUF_DEPTH - 1));
  assign txTake    = ce && state_q == ST_SEND && txReady && !activate;

  // Decision for a completed frame; errors get no answer so the reader times out
  always_comb
  begin
    act    = iso_block_pkg::ACT_NONE;
    bnNext = bn_q;
    if (rxCrcOk && !rxBad_q)
    begin
      case (blk)
        iso_block_pkg::BLK_I:
        begin
          if (!pcbNow[iso_block_pkg::BIT_CHAIN])
          begin
            act    = iso_block_pkg::ACT_APP;
            bnNext = !bn_q;
          end
          else if (rxCnt_q >= 9'(iso_block_pkg::CHAIN_MIN))
          begin
            act    = iso_block_pkg::ACT_RACK;
            bnNext = !bn_q;
          end
        end
        iso_block_pkg::BLK_R:
        begin
          if (pcbNow[iso_block_pkg::BIT_BN] == bn_q)
          begin
            if (lastIValid_q)
              act = iso_block_pkg::ACT_RETX;
          end
          else if (pcbNow[iso_block_pkg::BIT_NAK])
            act = iso_block_pkg::ACT_RACK;
          else
          begin
            bnNext = !bn_q;
            if (chainTx_q)
              act = iso_block_pkg::ACT_APP;
          end
        end
        iso_block_pkg::BLK_S:
          act = iso_block_pkg::ACT_SDES;
        default:
          act = iso_block_pkg::ACT_NONE;
      endcase
    end
  end

  // Receive side: header capture and frame length guard
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || (ce && activate))
    begin
      rxPcb_q <= 8'h00;
      rxCnt_q <= 9'h000;
      rxBad_q <= 1'b0;
    end
    else if (rxTake)
    begin
      if (rxLast)
      begin
        rxCnt_q <= 9'h000;
        rxBad_q <= 1'b0;
      end
      else if (!rxBad_q)
      begin
        if (rxCnt_q == 9'h000)
          rxPcb_q <= rxByte;
        rxCnt_q <= rxCnt_q + 9'h001;
        if (rxCnt_q + 9'h001 >= 9'(iso_block_pkg::DATA_MAX))
          rxBad_q <= 1'b1;
      end
    end
  end

  // Forward INF bytes of I-blocks; appGood tells the app whether to keep them
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      appValid_q   <= 1'b0;
      appByte_q    <= 8'h00;
      appEnd_q     <= 1'b0;
      appGood_q    <= 1'b0;
      appChained_q <= 1'b0;
    end
    else if (ce)
    begin
      appValid_q <= rxTake && rxCnt_q != 9'h000 && !rxBad_q && classify(rxPcb_q) == iso_block_pkg::BLK_I;
      appByte_q  <= rxByte;
      appEnd_q   <= fe && blk == iso_block_pkg::BLK_I;
      if (fe)
      begin
        appGood_q    <= blk == iso_block_pkg::BLK_I && act != iso_block_pkg::ACT_NONE;
        appChained_q <= pcbNow[iso_block_pkg::BIT_CHAIN];
      end
    end
  end

  // Block number and chain state
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || (ce && activate))
    begin
      bn_q         <= iso_block_pkg::BN_INIT;
      chainTx_q    <= 1'b0;
      lastIValid_q <= 1'b0;
    end
    else if (fe)
      bn_q <= bnNext;
    else if (txTake && txLast && deselPend_q)
    begin
      bn_q         <= iso_block_pkg::BN_INIT;
      chainTx_q    <= 1'b0;
      lastIValid_q <= 1'b0;
    end
    else if (replyEnd)
    begin
      chainTx_q    <= replyMore && (wr_q + 8'h01 >= 8'(iso_block_pkg::CHAIN_MIN));
      lastIValid_q <= 1'b1;
    end
  end

  // Reply buffer, kept whole so a retransmission is bit-identical
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wr_q  <= 8'h00;
      len_q <= 8'h00;
    end
    else if (fe)
      wr_q <= 8'h00;
    else if (replyTake)
    begin
      buf_q[wr_q] <= replyByte;
      wr_q        <= wr_q + 8'h01;
      if (replyEnd)
        len_q <= wr_q + 8'h01;
    end
  end

  // Protocol sequencer; transmission starts only from a received block
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || (ce && activate))
    begin
      state_q     <= ST_IDLE;
      txPcb_q     <= 8'h00;
      lastIPcb_q  <= 8'h00;
      shortTx_q   <= 1'b0;
      deselPend_q <= 1'b0;
      txIdx_q     <= 9'h000;
    end
    else if (ce)
    begin
      case (state_q)
        ST_IDLE:
        begin
          txIdx_q <= 9'h000;
          if (fe)
          begin
            case (act)
              iso_block_pkg::ACT_APP:
                state_q <= ST_APP;
              iso_block_pkg::ACT_RACK:
              begin
                txPcb_q   <= iso_block_pkg::PCB_R_ACK | {7'h00, bnNext};
                shortTx_q <= 1'b1;
                state_q   <= ST_SEND;
              end
              iso_block_pkg::ACT_RETX:
              begin
                txPcb_q   <= lastIPcb_q;
                shortTx_q <= 1'b0;
                state_q   <= ST_SEND;
              end
              iso_block_pkg::ACT_SDES:
              begin
                txPcb_q     <= iso_block_pkg::PCB_S_DESEL;
                shortTx_q   <= 1'b1;
                deselPend_q <= 1'b1;
                state_q     <= ST_SEND;
              end
              default:
                state_q <= ST_IDLE;
            endcase
          end
        end
        ST_APP:
        begin
          if (replyEnd)
          begin
            // Short chained segments go out unchained rather than break the minimum size
            txPcb_q <= iso_block_pkg::PCB_I_BASE | {3'h0, replyMore && (wr_q + 8'h01 >=
                       8'(iso_block_pkg::CHAIN_MIN)), 3'h0, bn_q};
            lastIPcb_q <= iso_block_pkg::PCB_I_BASE | {3'h0, replyMore && (wr_q + 8'h01 >=
                          8'(iso_block_pkg::CHAIN_MIN)), 3'h0, bn_q};
            shortTx_q  <= 1'b0;
            state_q    <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (txTake)
          begin
            txIdx_q <= txIdx_q + 9'h001;
            if (txLast)
              state_q <= deselPend_q ? ST_HALT : ST_IDLE;
          end
        end
        ST_HALT:
          state_q <= ST_HALT;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign txValid    = state_q == ST_SEND;
  assign txByte     = (txIdx_q == 9'h000) ? txPcb_q : buf_q[8'(txIdx_q - 9'h001)];
  assign txLast     = txValid && (shortTx_q ? txIdx_q == 9'h000 : txIdx_q == {1'b0, len_q});
  assign appValid   = appValid_q;
  assign appByte    = appByte_q;
  assign appEnd     = appEnd_q;
  assign appGood    = appGood_q;
  assign appChained = appChained_q;
  assign deselected = state_q == ST_HALT;
  assign blockNum   = bn_q;
  assign chaining   = chainTx_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  bn_init_a: assert property (ce && activate |=> bn_q && !chainTx_q)
    else $error("block number not 1 after activation");
  bn_toggle_i_a: assert property (fe && blk == iso_block_pkg::BLK_I && act != iso_block_pkg::ACT_NONE
    |=> bn_q != $past(bn_q))
    else $error("I-block did not toggle block number");
  nak_keep_a: assert property (fe && blk == iso_block_pkg::BLK_R && pcbNow[iso_block_pkg::BIT_NAK]
    && pcbNow[0] != bn_q |=> $stable(bn_q) && txPcb_q == (iso_block_pkg::PCB_R_ACK | {7'h00, bn_q}))
    else $error("differing NAK not answered by R(ACK)");
  retx_same_a: assert property (fe && act == iso_block_pkg::ACT_RETX
    |=> txValid && txPcb_q == $past(lastIPcb_q) && !shortTx_q)
    else $error("retransmitted block header differs");
  desel_pair_a: assert property (fe && blk == iso_block_pkg::BLK_S && rxCrcOk && !rxBad_q
    |=> txValid && txPcb_q == iso_block_pkg::PCB_S_DESEL && txLast)
    else $error("DESELECT not answered");
  chain_ack_a: assert property (fe && act == iso_block_pkg::ACT_RACK && blk == iso_block_pkg::BLK_I
    |=> (txPcb_q & 8'hFE) == iso_block_pkg::PCB_R_ACK)
    else $error("chained I-block not acknowledged");
  no_cid_a: assert property (txValid |-> !txPcb_q[iso_block_pkg::BIT_CID] && !txPcb_q[iso_block_pkg::BIT_NAD])
    else $error("CID or NAD bit sent");
  no_wtx_a: assert property (txValid |-> txPcb_q != iso_block_pkg::PCB_S_WTX)
    else $error("WTX request sent");
  answer_only_a: assert property ($rose(txValid) |-> $past(fe) || $past(replyEnd))
    else $error("transmission without a received block");
  chain_min_a: assert property (replyEnd && wr_q < 8'(iso_block_pkg::CHAIN_MIN - 1) |=> !chainTx_q)
    else $error("short segment marked as chained");

  reply_i_c: cover property (fe && act == iso_block_pkg::ACT_APP ##[1:300] txValid && txLast);
  chain_rx_c: cover property (fe && act == iso_block_pkg::ACT_RACK);
  retx_c: cover property (fe && act == iso_block_pkg::ACT_RETX);
  desel_c: cover property (fe && act == iso_block_pkg::ACT_SDES ##[1:20] deselected);
endmodule : iso14443_4_block_protocol
`default_nettype wire

// *** tb/reader_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module reader_model (
  input  wire logic       clk_sys,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  output logic            rxLast,
  output logic            rxCrcOk,
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  input  wire logic       txLast,
  output logic            txReady
);
  logic [7:0] got[$];
  int         lastPos = 0;
  logic       slow = 1'b0;
  initial
  begin
    rxValid = 1'b0;
    rxByte = 8'hA5;
    rxLast = 1'b0;
    rxCrcOk = 1'b0;
    txReady = 1'b1;
  end
  // Slow mode stalls every other cycle so held tx bytes get exercised
  always @(negedge clk_sys) txReady <= slow ? ~txReady : 1'b1;
  always @(posedge clk_sys)
  begin
    if (txValid === 1'b1 && txReady === 1'b1)
    begin
      got.push_back(txByte);
      if (txLast === 1'b1) lastPos = got.size() - 1;
    end
  end
  // The reader always opens an exchange
  task automatic send(input logic [7:0] f[$], input logic ok);
    foreach (f[k])
    begin
      @(negedge clk_sys);
      rxValid = 1'b1;
      rxByte = f[k];
      rxLast = (k == f.size() - 1);
      rxCrcOk = ok;
    end
    @(negedge clk_sys);
    rxValid = 1'b0;
    rxLast = 1'b0;
    // Idle line shows a changed value so stale bytes cannot match
    rxByte = ~rxByte;
  endtask : send
endmodule : reader_model
`default_nettype wire

// *** tb/iso14443_4_block_protocol_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module iso14443_4_block_protocol_test;
  logic       clk_sys = 1'b0;
  logic       rstn = 1'b0;
  logic       ce = 1'b1;
  logic       activate = 1'b0;
  logic       rxValid, rxLast, rxCrcOk, txReady, txValid, txLast;
  logic       appValid, appEnd, appGood, appChained, replyReady;
  logic       deselected, blockNum, chaining, endGood, endChn;
  logic [7:0] rxByte, appByte, txByte;
  logic [7:0] replyByte = 8'h00;
  logic       replyValid = 1'b0;
  logic       replyLast = 1'b0;
  logic       replyMore = 1'b0;
  logic [7:0] f[$];
  logic [7:0] appQ[$];
  int         n_mismatch = 0;
  int         tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  iso14443_4_block_protocol u_dut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .activate(activate),
    .rxValid(rxValid), .rxByte(rxByte), .rxLast(rxLast), .rxCrcOk(rxCrcOk), .appValid(appValid),
    .appByte(appByte), .appEnd(appEnd), .appGood(appGood), .appChained(appChained),
    .replyValid(replyValid), .replyByte(replyByte), .replyLast(replyLast), .replyMore(replyMore),
    .replyReady(replyReady), .txValid(txValid), .txByte(txByte), .txLast(txLast), .txReady(txReady),
    .deselected(deselected), .blockNum(blockNum), .chaining(chaining));
  reader_model u_rdr (.clk_sys(clk_sys), .rxValid(rxValid), .rxByte(rxByte), .rxLast(rxLast),
    .rxCrcOk(rxCrcOk), .txValid(txValid), .txByte(txByte), .txLast(txLast), .txReady(txReady));
  always @(posedge clk_sys)
  begin
    if (appValid === 1'b1) appQ.push_back(appByte);
    if (appEnd === 1'b1)
    begin
      endGood = appGood;
      endChn = appChained;
    end
  end
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic frame(input logic [7:0] pcb, input int n, input logic ok);
    f = {pcb};
    for (int k = 0; k < n; k++) f.push_back(8'h30 + k[7:0]);
    u_rdr.send(f, ok);
  endtask : frame
  task automatic reply(input int n, input logic more);
    int w;
    w = 0;
    while (replyReady !== 1'b1 && w < 50)
    begin
      @(negedge clk_sys);
      w++;
    end
    check(replyReady, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      replyValid = 1'b1;
      replyByte = 8'h60 + k[7:0];
      replyLast = (k == n - 1);
      replyMore = more;
      @(negedge clk_sys);
    end
    replyValid = 1'b0;
    replyLast = 1'b0;
  endtask : reply
  // Expects PCB then n reply bytes, last byte flagged
  task automatic expect_tx(input logic [7:0] pcb, input int n);
    int w;
    w = 0;
    while ((u_rdr.got.size() < n + 1 || txValid !== 1'b0) && w < 2000)
    begin
      @(negedge clk_sys);
      w++;
    end
    check(u_rdr.got.size(), n + 1);
    check(u_rdr.got[0], pcb);
    for (int k = 0; k < n; k++) check(u_rdr.got[k + 1], 8'h60 + k[7:0]);
    check(u_rdr.lastPos[7:0], n[7:0]);
    u_rdr.got.delete();
  endtask : expect_tx
  task automatic quiet();
    repeat (6) @(negedge clk_sys);
    check(u_rdr.got.size(), 0);
    check(replyReady, 1'b0);
  endtask : quiet
  task automatic act();
    activate = 1'b1;
    @(negedge clk_sys);
    activate = 1'b0;
    @(negedge clk_sys);
    check(blockNum, 1'b1);
    check(chaining, 1'b0);
    appQ.delete();
  endtask : act
  task automatic t_reset();
    quiet();
    check(blockNum, 1'b1);
    check(chaining, 1'b0);
    check(deselected, 1'b0);
  endtask : t_reset
  task automatic t_iblock();
    frame(8'h02, 1, 1'b1);
    repeat (2) @(negedge clk_sys);
    check(appQ[0], 8'h30);
    check(endGood, 1'b1);
    check(blockNum, 1'b0);
    reply(1, 1'b0);
    expect_tx(8'h02, 1);
  endtask : t_iblock
  task automatic t_rblocks();
    u_rdr.slow = 1'b1;
    frame(8'hB2, 0, 1'b1);
    expect_tx(8'h02, 1);
    frame(8'hA2, 0, 1'b1);
    expect_tx(8'h02, 1);
    u_rdr.slow = 1'b0;
    frame(8'hB3, 0, 1'b1);
    expect_tx(8'hA2, 0);
    check(blockNum, 1'b0);
    // Reader's next I-block carries 0; the tag toggles to 1 and answers with a new I-block
    frame(8'h02, 1, 1'b1);
    reply(1, 1'b0);
    expect_tx(8'h03, 1);
  endtask : t_rblocks
  task automatic t_rx_chain();
    act();
    frame(8'h12, 64, 1'b1);
    expect_tx(8'hA2, 0);
    check(endChn, 1'b1);
    frame(8'h03, 2, 1'b1);
    repeat (2) @(negedge clk_sys);
    check(endChn, 1'b0);
    check(appQ.size(), 66);
    reply(1, 1'b0);
    expect_tx(8'h03, 1);
  endtask : t_rx_chain
  task automatic t_tx_chain();
    act();
    frame(8'h02, 1, 1'b1);
    reply(64, 1'b1);
    expect_tx(8'h12, 64);
    check(chaining, 1'b1);
    frame(8'hA3, 0, 1'b1);
    reply(1, 1'b0);
    expect_tx(8'h03, 1);
    check(chaining, 1'b0);
    // More flagged on a short segment must still go out unchained
    frame(8'h02, 1, 1'b1);
    reply(2, 1'b1);
    expect_tx(8'h02, 2);
    check(chaining, 1'b0);
  endtask : t_tx_chain
  task automatic t_refuse();
    act();
    // Clock enable low: offered bytes must be dropped and state frozen
    ce = 1'b0;
    frame(8'h02, 1, 1'b1);
    quiet();
    ce = 1'b1;
    check(blockNum, 1'b1);
    frame(8'h0A, 1, 1'b1);
    quiet();
    frame(8'h06, 1, 1'b1);
    quiet();
    frame(8'hF2, 0, 1'b1);
    quiet();
    frame(8'h02, 1, 1'b0);
    quiet();
    check(endGood, 1'b0);
    frame(8'h02, 254, 1'b1);
    quiet();
    act();
    frame(8'h12, 63, 1'b1);
    quiet();
  endtask : t_refuse
  task automatic t_desel();
    act();
    frame(8'h02, 1, 1'b1);
    reply(1, 1'b0);
    expect_tx(8'h02, 1);
    // A corrupted DESELECT gets no answer, so the reader repeats it
    frame(8'hC2, 0, 1'b0);
    quiet();
    frame(8'hC2, 0, 1'b1);
    expect_tx(8'hC2, 0);
    check(deselected, 1'b1);
    check(blockNum, 1'b1);
    frame(8'h02, 1, 1'b1);
    quiet();
    act();
    check(deselected, 1'b0);
  endtask : t_desel
  initial
  begin
    #2000000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rstn = 1'b1;
    t_reset();
    t_iblock();
    t_rblocks();
    t_rx_chain();
    t_tx_chain();
    t_refuse();
    t_desel();
    give_verdict();
  end
endmodule : iso14443_4_block_protocol_test
`default_nettype wire
